// ### hw/diffserv_priority_map.sv
// DiffServ code point to frame priority map with an APB register bank
// Notes on behaviour
// - Frame code point is bits 7 to 2 of the TOS or traffic class byte.
// - Lowest map register gives 0x0C, 0x0D, 0x0E in bits 1-0, 3-2, 5-4.
// - Register 0x64 holds code points 0x10 to 0x13, two bits each, ascending.
// - Register 0x65 holds code points 0x14 to 0x17, ascending from bits 1-0.
// - Register 0x66 holds code points 0x18 to 0x1B, ascending from bits 1-0.
// - Register 0x67 holds code points 0x1C to 0x1F, ascending from bits 1-0.
// - Register 0x68 holds code points 0x20 to 0x23, ascending from bits 1-0.
// - Register 0x69 holds code points 0x24 to 0x27, ascending from bits 1-0.
// - Register 0x6A holds code points 0x28 to 0x2B, ascending from bits 1-0.
// - All fields are read/write and reset to 00, the lowest priority.
// - Register 0x63 bits 7-6 give the priority for code point 0x0F.
// - Register 0x6B holds code points 0x2C to 0x2F, each resetting to 00.
`timescale 1ns/1ps
module diffserv_priority_map
(
  // Clock and reset
  input wire logic pclk,
  input wire logic presetn,
  // APB slave
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [dscp_map_pkg::ADDR_W-1:0] paddr,
  input wire logic [dscp_map_pkg::DATA_W-1:0] pwdata,
  input wire logic [3:0] pstrb,
  output logic [dscp_map_pkg::DATA_W-1:0] prdata,
  output logic pready,
  output logic pslverr,
  // Frame lookup request, same clock
  input wire logic tos_valid,
  input wire logic [7:0] tos_byte,
  // Priority to egress queue selection
  output logic prio_valid,
  output logic [dscp_map_pkg::PRIO_W-1:0] prio,
  output logic prio_hit
);

  typedef struct packed
  {
    logic [dscp_map_pkg::MAP_REGS-1:0][dscp_map_pkg::REG_W-1:0] map;
    logic [dscp_map_pkg::DATA_W-1:0] rdata;
    logic ready;
    logic slverr;
  } state_type;

  state_type q;
  state_type next_q;
  lookup_if lk();

  // ----------------------------------------------------------------
  // Address decode
  // ----------------------------------------------------------------
  logic [dscp_map_pkg::INDEX_W-1:0] index;
  logic mapped;
  logic [3:0] slot;

  always_comb
  begin
    index = paddr[dscp_map_pkg::ADDR_W-1:2];
    // Index 0x63 is the first map register, 0x6B the last
    mapped = (paddr[1:0] == 2'h0)
      && (index >= dscp_map_pkg::IDX_DIFFSERV_MAP_0C_0F)
      && (index <= dscp_map_pkg::IDX_DIFFSERV_MAP_2C_2F);
    slot = 4'(index - dscp_map_pkg::IDX_DIFFSERV_MAP_0C_0F);
  end

  // ----------------------------------------------------------------
  // Register bank and bus answer
  // ----------------------------------------------------------------
  always_comb
  begin
    next_q = q;
    // Answer one cycle after setup, so every transfer has one access cycle
    next_q.ready = psel && !penable;
    next_q.slverr = psel && !penable && !mapped;
    if (psel && !penable)
    begin
      next_q.rdata = '0;
      if (mapped && !pwrite)
      begin
        // Upper 24 bits read as zero
        next_q.rdata[dscp_map_pkg::REG_W-1:0] = q.map[slot];
      end
    end
    // Write lands at the edge that samples pready high
    if (psel && penable && q.ready && pwrite && mapped && pstrb[0])
    begin
      next_q.map[slot] = pwdata[dscp_map_pkg::REG_W-1:0];
    end
  end

  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      q.map <= {dscp_map_pkg::MAP_REGS{dscp_map_pkg::MAP_RESET}};
      q.rdata <= '0;
      q.ready <= 1'h0;
      q.slverr <= 1'h0;
    end
    else
    begin
      q <= next_q;
    end
  end

  // ----------------------------------------------------------------
  // Lookup engine
  // ----------------------------------------------------------------
  // Table is presented flat; the engine picks a field by code point offset
  assign lk.map_table = q.map;
  assign lk.req_valid = tos_valid;
  assign lk.req_tos = tos_byte;

  priority_lookup engine
  (
    .pclk(pclk),
    .presetn(presetn),
    .lk(lk)
  );

  assign prdata = q.rdata;
  assign pready = q.ready;
  assign pslverr = q.slverr;
  assign prio_valid = lk.rsp_valid;
  assign prio = lk.rsp_prio;
  assign prio_hit = lk.rsp_hit;

endmodule

// ### hw/dscp_map_pkg.sv
// Constants shared by the DiffServ priority map and its lookup engine
package dscp_map_pkg;

  // ----------------------------------------------------------------
  // Register bus geometry
  // ----------------------------------------------------------------
  localparam int ADDR_W = 12;
  localparam int DATA_W = 32;
  localparam int REG_W = 8;
  localparam int INDEX_W = 10;

  // ----------------------------------------------------------------
  // Register indices; byte address is four times the index
  // ----------------------------------------------------------------
  localparam logic [INDEX_W-1:0] IDX_DIFFSERV_MAP_0C_0F = 10'h063;
  localparam logic [INDEX_W-1:0] IDX_DIFFSERV_MAP_10_13 = 10'h064;
  localparam logic [INDEX_W-1:0] IDX_DIFFSERV_MAP_14_17 = 10'h065;
  localparam logic [INDEX_W-1:0] IDX_DIFFSERV_MAP_18_1B = 10'h066;
  localparam logic [INDEX_W-1:0] IDX_DIFFSERV_MAP_1C_1F = 10'h067;
  localparam logic [INDEX_W-1:0] IDX_DIFFSERV_MAP_20_23 = 10'h068;
  localparam logic [INDEX_W-1:0] IDX_DIFFSERV_MAP_24_27 = 10'h069;
  localparam logic [INDEX_W-1:0] IDX_DIFFSERV_MAP_28_2B = 10'h06A;
  localparam logic [INDEX_W-1:0] IDX_DIFFSERV_MAP_2C_2F = 10'h06B;
  localparam int MAP_REGS = 9;

  // ----------------------------------------------------------------
  // Field layout and reset values
  // ----------------------------------------------------------------
  localparam int PRIO_W = 2;
  localparam int FIELDS_PER_REG = 4;
  localparam int CODE_W = 6;
  localparam int CODE_LSB = 2;
  localparam logic [CODE_W-1:0] FIRST_CODE = 6'h0C;
  localparam logic [CODE_W-1:0] LAST_CODE = 6'h2F;
  localparam logic [REG_W-1:0] MAP_RESET = 8'h00;
  localparam logic [PRIO_W-1:0] PRIO_RESET = 2'h0;
  localparam int TABLE_W = MAP_REGS * REG_W;

endpackage

// ### hw/lookup_if.sv
// Carrier between the register bank and the priority lookup engine
`timescale 1ns/1ps
interface lookup_if;
  logic req_valid;
  logic [7:0] req_tos;
  logic [dscp_map_pkg::TABLE_W-1:0] map_table;
  logic rsp_valid;
  logic [dscp_map_pkg::PRIO_W-1:0] rsp_prio;
  logic rsp_hit;

  modport requester
  (
    output req_valid,
    output req_tos,
    output map_table,
    input rsp_valid,
    input rsp_prio,
    input rsp_hit
  );

  modport engine
  (
    input req_valid,
    input req_tos,
    input map_table,
    output rsp_valid,
    output rsp_prio,
    output rsp_hit
  );
endinterface

// ### hw/priority_lookup.sv
// Registered lookup of a frame priority from the packed DiffServ table
`timescale 1ns/1ps
module priority_lookup
(
  // Clock and reset
  input wire logic pclk,
  input wire logic presetn,
  // Lookup carrier
  lookup_if.engine lk
);

  typedef struct packed
  {
    logic valid;
    logic [dscp_map_pkg::PRIO_W-1:0] prio;
    logic hit;
  } state_type;

  state_type q;
  state_type next_q;

  always_comb
  begin
    logic [dscp_map_pkg::CODE_W-1:0] code;
    logic [dscp_map_pkg::CODE_W-1:0] entry;
    code = '0;
    entry = '0;
    next_q = q;
    next_q.valid = lk.req_valid;
    if (lk.req_valid)
    begin
      // Code point is the upper six bits of the TOS or traffic class byte
      code = lk.req_tos[7:dscp_map_pkg::CODE_LSB];
      if (code >= dscp_map_pkg::FIRST_CODE && code <= dscp_map_pkg::LAST_CODE)
      begin
        // Four fields per byte, lowest code point in bits 1-0
        entry = code - dscp_map_pkg::FIRST_CODE;
        next_q.prio = lk.map_table[entry*dscp_map_pkg::PRIO_W +: dscp_map_pkg::PRIO_W];
        next_q.hit = 1'h1;
      end
      else
      begin
        // Code points outside this bank fall back to the lowest level
        next_q.prio = dscp_map_pkg::PRIO_RESET;
        next_q.hit = 1'h0;
      end
    end
  end

  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      q <= '0;
    end
    else
    begin
      q <= next_q;
    end
  end

  assign lk.rsp_valid = q.valid;
  assign lk.rsp_prio = q.prio;
  assign lk.rsp_hit = q.hit;

endmodule

// ### sim/dpm_chk_assertions.sv
// Port-level assertions for the DiffServ priority map
`timescale 1ns/1ps
module dpm_chk
(
  // Clock and reset
  input wire logic pclk,
  input wire logic presetn,
  // APB
  input wire logic psel,
  input wire logic penable,
  input wire logic [31:0] prdata,
  input wire logic pready,
  input wire logic pslverr,
  // Lookup
  input wire logic tos_valid,
  input wire logic [7:0] tos_byte,
  input wire logic prio_valid,
  input wire logic [1:0] prio,
  input wire logic prio_hit
);
  default clocking @(posedge pclk);
  endclocking
  default disable iff (!presetn);
  // ----------------------------------------------------------------
  // Sequences
  // ----------------------------------------------------------------
  sequence s_setup;
    psel && !penable;
  endsequence
  sequence s_in;
    tos_valid && tos_byte[7:2] inside {[6'h0C:6'h2F]};
  endsequence
  property p_ack; s_setup |=> pready; endproperty
  a_ack: assert property (p_ack) else $error("no ready after setup");
  property p_rdy; pready |-> psel && penable; endproperty
  a_rdy: assert property (p_rdy) else $error("ready outside access");
  property p_err; pslverr |-> pready; endproperty
  a_err: assert property (p_err) else $error("error without ready");
  property p_hi; pready |-> prdata[31:8] == 24'h0; endproperty
  a_hi: assert property (p_hi) else $error("upper read bits set");
  property p_lat; tos_valid |=> prio_valid; endproperty
  a_lat: assert property (p_lat) else $error("lookup answer late");
  property p_spur; prio_valid |-> $past(tos_valid); endproperty
  a_spur: assert property (p_spur) else $error("spurious answer");
  property p_hit; s_in |=> prio_hit; endproperty
  a_hit: assert property (p_hit) else $error("hit missing");
  // Plain range test instead of a sequence end point, so free tools accept it
  property p_miss;
    tos_valid && !(tos_byte[7:2] inside {[6'h0C:6'h2F]}) |=> !prio_hit && prio == 2'h0;
  endproperty
  a_miss: assert property (p_miss) else $error("miss not clean");
  property p_hold; !tos_valid |=> $stable(prio) && $stable(prio_hit); endproperty
  a_hold: assert property (p_hold) else $error("priority moved");
endmodule
bind diffserv_priority_map dpm_chk u_chk (.pclk, .presetn, .psel, .penable, .prdata,
  .pready, .pslverr, .tos_valid, .tos_byte, .prio_valid, .prio, .prio_hit);

// ### sim/tb_top.sv
// Directed testbench for the DiffServ priority map
`timescale 1ns/1ps
module tb_top;
  logic pclk, presetn, psel, penable, pwrite, pready, pslverr, tos_valid, prio_valid, prio_hit;
  logic [11:0] paddr;
  logic [31:0] pwdata, prdata, r;
  logic [3:0] pstrb;
  logic [7:0] tos_byte;
  logic [1:0] prio;
  logic [7:0] wv [9];
  logic e;
  int err_count, checks_done, i, c;
  diffserv_priority_map u_dut (.pclk, .presetn, .psel, .penable, .pwrite, .paddr, .pwdata,
    .pstrb, .prdata, .pready, .pslverr, .tos_valid, .tos_byte, .prio_valid, .prio, .prio_hit);
  initial
  begin
    pclk = 0;
    forever #2.5 pclk = ~pclk;
  end
  // ----------------------------------------------------------------
  // Tasks
  // ----------------------------------------------------------------
  task automatic final_report;
    if (err_count == 0 && checks_done > 0)
      $display("verification passed");
    else
      $display("verification failed");
    $finish;
  endtask
  task automatic chk(input string nm, input logic [31:0] g, input logic [31:0] x);
    checks_done++;
    if (g !== x)
    begin
      $display("[ERR] %s exp %h got %h", nm, x, g);
      err_count++;
    end
  endtask
  task automatic apb(input logic w, input logic [11:0] a, input logic [31:0] d,
    input logic [3:0] s);
    int n;
    @(posedge pclk);
    psel <= 1;
    penable <= 0;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    pstrb <= s;
    @(posedge pclk);
    penable <= 1;
    n = 0;
    do
    begin
      @(posedge pclk);
      n++;
    end
    while (pready !== 1'b1 && n < 20);
    if (pready !== 1'b1)
    begin
      err_count++;
      final_report();
    end
    else
    begin
      r = prdata;
      e = pslverr;
      psel <= 0;
      penable <= 0;
    end
  endtask
  // Answer comes one edge after the request edge, so sample two edges on
  task automatic look(input logic [7:0] t, input logic [1:0] p, input logic h);
    @(posedge pclk);
    tos_valid <= 1;
    tos_byte <= t;
    @(posedge pclk);
    tos_valid <= 0;
    @(posedge pclk);
    chk("valid", {31'h0, prio_valid}, 32'h1);
    chk("prio", {30'h0, prio}, {30'h0, p});
    chk("hit", {31'h0, prio_hit}, {31'h0, h});
  endtask
  // ----------------------------------------------------------------
  // Sequence
  // ----------------------------------------------------------------
  initial
  begin
    {presetn, psel, penable, pwrite, tos_valid} = 5'h00;
    {paddr, pwdata, pstrb, tos_byte} = '0;
    err_count = 0;
    checks_done = 0;
    repeat (2) @(posedge pclk);
    presetn <= 1;
    for (i = 0; i < 9; i++)
    begin
      apb(0, 12'(12'h18C + 4 * i), 32'h0, 4'hF);
      chk("reset", r, 32'h0);
      wv[i] = 8'(8'h1B + 8'h35 * i);
      apb(1, 12'(12'h18C + 4 * i), {24'hFFFFFF, wv[i]}, 4'hF);
      chk("werr", {31'h0, e}, 32'h0);
    end
    for (i = 0; i < 9; i++)
    begin
      apb(0, 12'(12'h18C + 4 * i), 32'h0, 4'hF);
      chk("read", r, {24'h0, wv[i]});
    end
    // Low two TOS bits follow the code so a wrong slice picks another field
    for (c = 12; c < 48; c++)
      look(8'(c * 4 + c % 4), 2'(wv[(c - 12) / 4] >> (2 * (c % 4))), 1);
    look(8'h2F, 2'h0, 0);
    look(8'hC0, 2'h0, 0);
    apb(1, 12'h190, 32'h00, 4'h0);
    apb(0, 12'h190, 32'h0, 4'hF);
    chk("strobe", r, {24'h0, wv[1]});
    apb(1, 12'h1B0, 32'hFF, 4'hF);
    chk("unmapped", {31'h0, e}, 32'h1);
    apb(0, 12'h191, 32'h0, 4'hF);
    chk("misalign", {31'h0, e}, 32'h1);
    chk("misdata", r, 32'h0);
    // Mid-run reset must clear written fields back to the lowest level; register 0x6B and code point 0x14 are checked
    presetn <= 1'h0;
    @(posedge pclk);
    presetn <= 1'h1;
    apb(0, 12'h1AC, 32'h0, 4'hF);
    chk("rst_read", r, 32'h0);
    look(8'h50, 2'h0, 1'h1);
    final_report();
  end
endmodule
